// ===== verilog/spi_pkg.sv
// constants for the status pin, strap and interrupt block: register map,
// field layout, reset values, strap timing and the startup tuning word table.
// assumes a 125 MHz APB clock and six status flags from the synthesizer core.
// Operation
// - each pin ORs any chosen status flags
// - reference flags come from one selected reference
// - loss or out-of-limit enabled both assert pin
// - short internal reset pulse tristates pins
// - pulse end captures pins, restores outputs
// - external reset repeats strap sampling
// - low strap bits index eight-word tuning table
// - table word loads startup tuning word directly
// - strap bit three selects clock source
// - crystal mode defaults multiplier to forty
// - table words give the listed output frequencies
// - loop stays open until software closes it
// - any pin may carry the interrupt flag
// - live flags readable in status register
// - flags trigger on changes, some one-way
// - unmasked event latches active-high interrupt
// - interrupt assertion snapshots status register
// - reset bit clears flag, snapshot, detectors
// - pins float while external reset held
package spi_pkg;
   localparam int NUM_PINS = 4;
   localparam int NUM_FLAGS = 6;
   // flag positions in the status word
   localparam int FLG_LOSS_A = 0;
   localparam int FLG_LOSS_B = 1;
   localparam int FLG_LIMIT_A = 2;
   localparam int FLG_LIMIT_B = 3;
   localparam int FLG_FEST_DONE = 4;
   localparam int FLG_LOCKED = 5;
   // flags that count a change in both directions; the rest only on rise
   localparam logic [5:0] BOTH_EDGE_MASK = 6'h2f;
   // register byte offsets
   localparam logic [7:0] OFS_PIN_CFG = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_STRAP = 8'h14;
   localparam logic [7:0] OFS_START_TW = 8'h18;
   // per-pin config byte, pin n at bits 8n+7..8n
   localparam int CFG_BITS = 8;
   localparam int CFG_REF_SEL = 0;
   localparam int CFG_LOSS_EN = 1;
   localparam int CFG_LIMIT_EN = 2;
   localparam int CFG_FEST_EN = 3;
   localparam int CFG_LOCK_EN = 4;
   localparam int CFG_IRQ_SEL = 5;
   localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] PIN_CFG_WMASK = 32'h3f3f_3f3f;
   // control bits
   localparam int CTRL_IRQ_RESET = 0;
   localparam int CTRL_CLOSE_LOOP = 1;
   localparam logic [5:0] IRQ_MASK_RST = 6'h00;
   // strap pulse timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STRAP_PULSE_NS = 10;
   localparam int STRAP_CYCLES = (STRAP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // strap field and clock multiplier
   localparam int STRAP_CLK_BIT = 3;
   localparam logic [5:0] MULT_XTAL = 6'h28;
   localparam logic [5:0] MULT_DIRECT = 6'h01;
   // tuning words for a 1 GHz sample clock, word/65536 of it
   localparam logic [15:0] STRAP_ROM [0:7] = '{
      16'h0000, 16'h09f4, 16'h0d45, 16'h0fba,
      16'h13e8, 16'h1797, 16'h1f75, 16'h27d0};
   typedef enum logic [1:0] {
      SPI_ST_PULSE = 2'b00,
      SPI_ST_RUN = 2'b01
   } spi_strap_st_t;
endpackage : spi_pkg

// ===== verilog/spi_edge_det.sv
// change detector for the status flags, one armed bit per flag.
// assumes flags are synchronous to pclk; rearm comes from the ack bit.
`timescale 1ns/100ps
module spi_edge_det #(
   parameter int WIDTH = 6,
   parameter logic [WIDTH-1:0] BOTH_EDGES = '1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // flags and control
   input wire logic [WIDTH-1:0] flags,
   input wire logic rearm,
   // one-cycle change pulses
   output logic [WIDTH-1:0] events
);
   logic [WIDTH-1:0] last_ff;
   logic [WIDTH-1:0] armed_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         logic rise;
         logic fall;
         assign rise = flags[i] & ~last_ff[i];
         assign fall = ~flags[i] & last_ff[i];
         // one-way flags ignore the falling change
         assign events[i] = armed_ff[i] & (rise | (BOTH_EDGES[i] & fall));
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_ff <= '0;
      end else begin
         last_ff <= flags;
      end
   end

   // a detector fires once and waits for the ack to look again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_ff <= '1;
      end else if (rearm) begin
         armed_ff <= '1;
      end else begin
         armed_ff <= armed_ff & ~events;
      end
   end
endmodule : spi_edge_det

// ===== verilog/spi_status_irq.sv
// status pins, strap capture and interrupt logic with an APB register file.
// assumes presetn is the device reset pin (and the power-up reset), and that
// the pad ring resolves the status pins from the output enables.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
module spi_status_irq #(
   parameter int ADDR_W = 8
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // internal status flags
   input wire logic [5:0] status_flags,
   // status pins
   input wire logic [3:0] status_pin_i,
   output logic [3:0] status_pin_o,
   output logic [3:0] status_pin_oe,
   // startup configuration to the core
   output logic [15:0] startup_tuning_word_reg,
   output logic sample_clock_direct,
   output logic [5:0] clk_mult_ratio,
   output logic strap_done,
   output logic loop_closed,
   output logic irq_flag
);
   generate
      if (ADDR_W < 8) begin : g_chk
         $error("spi_status_irq: ADDR_W must be at least 8");
      end
   endgenerate

   // strap sequencer
   spi_pkg::spi_strap_st_t st_ff;
   logic [1:0] pulse_cnt_ff;
   logic [3:0] strap_ff;
   logic capture;

   // registers
   logic [31:0] pin_cfg_ff;
   logic [5:0] irq_mask_ff;
   logic [5:0] irq_status_ff;
   logic [15:0] start_tw_ff;
   logic close_loop_ff;
   logic irq_ff;
   logic [5:0] mult_ff;
   logic [31:0] prdata_ff;
   logic [3:0] pin_out_ff;
   logic [3:0] pin_oe_ff;

   // bus decode
   logic wr_acc;
   logic rd_setup;
   logic [7:0] ofs;
   logic hit;
   logic irq_ack;
   logic [31:0] nxt_rdata;

   // interrupt path
   logic [5:0] events;
   logic irq_set;

   assign ofs = paddr[7:0];
   assign wr_acc = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   always_comb begin
      hit = 1'b1;
      case (ofs)
         spi_pkg::OFS_PIN_CFG,
         spi_pkg::OFS_CTRL,
         spi_pkg::OFS_STATUS,
         spi_pkg::OFS_IRQ_MASK,
         spi_pkg::OFS_IRQ_STATUS,
         spi_pkg::OFS_STRAP,
         spi_pkg::OFS_START_TW: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      // a shift keeps this legal when the bus is exactly eight bits wide
      if ((paddr >> 8) != '0) begin
         hit = 1'b0;
      end
   end

   // zero wait states: every transfer completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // the ack is a write-one pulse; it is never stored
   assign irq_ack = wr_acc & hit & (ofs == spi_pkg::OFS_CTRL) & pwdata[spi_pkg::CTRL_IRQ_RESET];

   // power-up and pin reset both land here, so both get the same strap pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= spi_pkg::SPI_ST_PULSE;
         pulse_cnt_ff <= 2'h0;
      end else begin
         case (st_ff)
            spi_pkg::SPI_ST_PULSE: begin
               if (capture) begin
                  st_ff <= spi_pkg::SPI_ST_RUN;
               end else begin
                  pulse_cnt_ff <= pulse_cnt_ff + 2'h1;
               end
            end
            spi_pkg::SPI_ST_RUN: begin
               st_ff <= spi_pkg::SPI_ST_RUN;
            end
            default: begin
               st_ff <= spi_pkg::SPI_ST_PULSE;
            end
         endcase
      end
   end

   // end of the internal pulse: the last cycle of the count
   assign capture = (st_ff == spi_pkg::SPI_ST_PULSE) &
                    (pulse_cnt_ff == 2'(spi_pkg::STRAP_CYCLES - 1));

   // pins are sampled by a clocked process after reset release, never by the reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_ff <= 4'h0;
      end else if (capture) begin
         strap_ff <= status_pin_i;
      end
   end

   // pins float through reset and the pulse, drive once the strap is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe_ff <= 4'h0;
      end else if (capture) begin
         pin_oe_ff <= 4'hf;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult_ff <= 6'h00;
      end else if (capture) begin
         // bit three picks the direct input, otherwise crystal times forty
         mult_ff <= status_pin_i[spi_pkg::STRAP_CLK_BIT] ? spi_pkg::MULT_DIRECT
                                                         : spi_pkg::MULT_XTAL;
      end
   end

   // the table word goes straight in, no update strobe is waited for
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_tw_ff <= 16'h0000;
      end else if (capture) begin
         start_tw_ff <= spi_pkg::STRAP_ROM[status_pin_i[2:0]];
      end else if (wr_acc && hit && ofs == spi_pkg::OFS_START_TW) begin
         start_tw_ff <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_cfg_ff <= spi_pkg::PIN_CFG_RST;
      end else if (wr_acc && hit && ofs == spi_pkg::OFS_PIN_CFG) begin
         pin_cfg_ff <= pwdata & spi_pkg::PIN_CFG_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= spi_pkg::IRQ_MASK_RST;
      end else if (wr_acc && hit && ofs == spi_pkg::OFS_IRQ_MASK) begin
         irq_mask_ff <= pwdata[5:0];
      end
   end

   // open after every reset; only software closes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         close_loop_ff <= 1'b0;
      end else if (wr_acc && hit && ofs == spi_pkg::OFS_CTRL) begin
         close_loop_ff <= pwdata[spi_pkg::CTRL_CLOSE_LOOP];
      end
   end

   spi_edge_det #(
      .WIDTH(spi_pkg::NUM_FLAGS),
      .BOTH_EDGES(spi_pkg::BOTH_EDGE_MASK)
   ) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .flags(status_flags),
      .rearm(irq_ack),
      .events(events)
   );

   assign irq_set = |(events & irq_mask_ff);

   // an event in the ack cycle wins so it is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else if (irq_set) begin
         irq_ff <= 1'b1;
      end else if (irq_ack) begin
         irq_ff <= 1'b0;
      end
   end

   // snapshot only on the assertion, so later changes keep the first cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_ff <= 6'h00;
      end else if (irq_set && (!irq_ff || irq_ack)) begin
         irq_status_ff <= status_flags;
      end else if (irq_ack) begin
         irq_status_ff <= 6'h00;
      end
   end

   // per-pin selection
   genvar p;
   generate
      for (p = 0; p < spi_pkg::NUM_PINS; p++) begin : g_pin
         logic [7:0] cfg;
         logic ref_b;
         logic loss;
         logic lim;
         logic combo;
         assign cfg = pin_cfg_ff[p*spi_pkg::CFG_BITS +: spi_pkg::CFG_BITS];
         assign ref_b = cfg[spi_pkg::CFG_REF_SEL];
         // one reference only, picked by the select bit
         assign loss = ref_b ? status_flags[spi_pkg::FLG_LOSS_B]
                             : status_flags[spi_pkg::FLG_LOSS_A];
         assign lim = ref_b ? status_flags[spi_pkg::FLG_LIMIT_B]
                            : status_flags[spi_pkg::FLG_LIMIT_A];
         assign combo = (cfg[spi_pkg::CFG_LOSS_EN] & loss) |
                        (cfg[spi_pkg::CFG_LIMIT_EN] & lim) |
                        (cfg[spi_pkg::CFG_FEST_EN] & status_flags[spi_pkg::FLG_FEST_DONE]) |
                        (cfg[spi_pkg::CFG_LOCK_EN] & status_flags[spi_pkg::FLG_LOCKED]);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out_ff[p] <= 1'b0;
            end else if (cfg[spi_pkg::CFG_IRQ_SEL]) begin
               pin_out_ff[p] <= irq_ff;
            end else begin
               pin_out_ff[p] <= combo;
            end
         end
      end
   endgenerate

   // read data is fetched in the setup cycle and held through the access
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (ofs)
         spi_pkg::OFS_PIN_CFG: nxt_rdata = pin_cfg_ff;
         spi_pkg::OFS_CTRL: nxt_rdata = {30'h0000_0000, close_loop_ff, 1'b0};
         spi_pkg::OFS_STATUS: nxt_rdata = {26'h000_0000, status_flags};
         spi_pkg::OFS_IRQ_MASK: nxt_rdata = {26'h000_0000, irq_mask_ff};
         spi_pkg::OFS_IRQ_STATUS: nxt_rdata = {26'h000_0000, irq_status_ff};
         spi_pkg::OFS_STRAP: nxt_rdata = {16'h0000, 2'b00, mult_ff, 3'b000, strap_done, strap_ff};
         spi_pkg::OFS_START_TW: nxt_rdata = {16'h0000, start_tw_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
      if (!hit) begin
         nxt_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_ff <= nxt_rdata;
      end
   end

   assign prdata = prdata_ff;
   assign status_pin_o = pin_out_ff;
   assign status_pin_oe = pin_oe_ff;
   assign startup_tuning_word_reg = start_tw_ff;
   assign sample_clock_direct = strap_ff[spi_pkg::STRAP_CLK_BIT];
   assign clk_mult_ratio = mult_ff;
   assign strap_done = pin_oe_ff[0];
   assign loop_closed = close_loop_ff;
   assign irq_flag = irq_ff;
endmodule : spi_status_irq

// ===== bench/spi_status_irq_asserts.sv
// checker for the status pin block: strap capture, pin drive and interrupt latch.
// assumes it is bound to spi_status_irq and sees only its ports.
`timescale 1ns/100ps
module spi_status_irq_asserts #(
   parameter int ADDR_W = 8
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // flags and pins
   input wire logic [5:0] status_flags,
   input wire logic [3:0] status_pin_i,
   input wire logic [3:0] status_pin_oe,
   // startup and interrupt
   input wire logic [15:0] startup_tuning_word_reg,
   input wire logic sample_clock_direct,
   input wire logic [5:0] clk_mult_ratio,
   input wire logic strap_done,
   input wire logic loop_closed,
   input wire logic irq_flag
);
   logic ctrl_wr;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   assign ctrl_wr = psel && penable && pwrite && paddr == ADDR_W'(spi_pkg::OFS_CTRL);
   property p_oe_float;
      !strap_done |-> status_pin_oe == 4'h0;
   endproperty
   a_oe_float: assert property (p_oe_float)
      else $error("pins driven before strap");
   property p_strap_cap;
      $rose(strap_done) |-> status_pin_oe == 4'hf && sample_clock_direct == $past(status_pin_i[3])
         && startup_tuning_word_reg == spi_pkg::STRAP_ROM[$past(status_pin_i[2:0])];
   endproperty
   a_strap_cap: assert property (p_strap_cap)
      else $error("strap capture wrong");
   property p_mult;
      strap_done |-> clk_mult_ratio == (sample_clock_direct ? spi_pkg::MULT_DIRECT : spi_pkg::MULT_XTAL);
   endproperty
   a_mult: assert property (p_mult)
      else $error("multiplier wrong");
   property p_strap_hold;
      strap_done |=> strap_done && $stable(sample_clock_direct);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("strap lost");
   property p_irq_hold;
      irq_flag && !(ctrl_wr && pwdata[0]) |=> irq_flag;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without ack");
   property p_ack;
      ctrl_wr && pwdata[0] && $stable(status_flags) |=> !irq_flag;
   endproperty
   a_ack: assert property (p_ack)
      else $error("irq survived ack");
   property p_irq_cause;
      $rose(irq_flag) |-> $past(status_flags) != $past(status_flags, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq without flag change");
   property p_loop;
      !loop_closed && !(ctrl_wr && pwdata[1]) |=> !loop_closed;
   endproperty
   a_loop: assert property (p_loop)
      else $error("loop closed by itself");
endmodule : spi_status_irq_asserts

bind spi_status_irq spi_status_irq_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .status_flags(status_flags), .status_pin_i(status_pin_i), .status_pin_oe(status_pin_oe),
   .startup_tuning_word_reg(startup_tuning_word_reg), .sample_clock_direct(sample_clock_direct),
   .clk_mult_ratio(clk_mult_ratio), .strap_done(strap_done), .loop_closed(loop_closed),
   .irq_flag(irq_flag));

// ===== bench/spi_strap_res.sv
// strap resistors and pad ring on the four status pins.
// assumes oe high means the block drives the pin.
`timescale 1ns/100ps
module spi_strap_res (
   // block side
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe,
   // resistor pattern, 1 is a pull-up
   input wire logic [3:0] pull,
   // resolved level
   output logic [3:0] pin_lvl
);
   // a released pin goes to its resistor, never keeps the last driven level
   assign pin_lvl = (pin_o & pin_oe) | (pull & ~pin_oe);
endmodule : spi_strap_res

// ===== bench/spi_status_irq_bench.sv
// self-checking bench: pin routing, interrupts and a strap sweep over apb.
// assumes the resistor model resolves the status pins.
`timescale 1ns/100ps
module spi_status_irq_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic strap_done, loop_closed, irq_flag, sample_clock_direct;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, cfg;
   logic [5:0] status_flags, clk_mult_ratio;
   logic [3:0] pin_i, pin_o, pin_oe, pull;
   logic [15:0] startup_tuning_word_reg;
   int bad_count, checks;
   spi_status_irq #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status_flags(status_flags), .status_pin_i(pin_i), .status_pin_o(pin_o),
      .status_pin_oe(pin_oe), .startup_tuning_word_reg(startup_tuning_word_reg),
      .sample_clock_direct(sample_clock_direct), .clk_mult_ratio(clk_mult_ratio),
      .strap_done(strap_done), .loop_closed(loop_closed), .irq_flag(irq_flag));
   spi_strap_res u_res (.pin_o(pin_o), .pin_oe(pin_oe), .pull(pull), .pin_lvl(pin_i));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic test_done;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) bad_count++;
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic ack;
      apb(1'b1, spi_pkg::OFS_CTRL, 32'h1);
      cyc(1);
   endtask : ack
   task automatic setf(input logic [5:0] f);
      @(posedge pclk);
      status_flags <= f;
   endtask : setf
   task automatic rst(input logic [3:0] s, input int n);
      @(posedge pclk);
      status_flags <= 6'h0;
      presetn <= 1'b0;
      pull <= s;
      cyc(n);
      chk("oe in reset", 32'h0, 32'(pin_oe));
      presetn <= 1'b1;
      cyc(4);
   endtask : rst
   function automatic logic [15:0] exp_tw(input logic [2:0] i);
      real mhz [8] = '{0.0, 38.87939, 51.83411, 61.43188, 77.75879, 92.14783, 122.87903, 155.51758};
      return 16'($rtoi(mhz[i] * 65.536 + 0.5));
   endfunction : exp_tw
   function automatic logic [3:0] exp_pin(input logic [31:0] c, input logic [5:0] f);
      logic [3:0] p;
      logic [7:0] b;
      for (int n = 0; n < 4; n++) begin
         b = c[8*n +: 8];
         p[n] = (b[1] & f[b[0]]) | (b[2] & f[2 + b[0]]) | (b[3] & f[4]) | (b[4] & f[5]);
      end
      return p;
   endfunction : exp_pin
   initial begin
      #(8 * 20000);
      bad_count++;
      test_done();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      status_flags = 6'h0;
      pull = 4'h5;
      void'($urandom(88014));
      rst(4'h5, 20);
      repeat (40) begin
         cfg = $urandom() & 32'h1f1f_1f1f;
         apb(1'b1, spi_pkg::OFS_PIN_CFG, cfg);
         setf(6'($urandom()));
         cyc(2);
         chk("pins", 32'(exp_pin(cfg, status_flags)), 32'(pin_o));
         apb(1'b0, spi_pkg::OFS_STATUS, 32'h0);
         chk("status", 32'(status_flags), rd);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, 32'(serr));
      apb(1'b1, spi_pkg::OFS_PIN_CFG, 32'h20);
      for (int i = 0; i < 6; i++) begin
         setf(6'h0);
         apb(1'b1, spi_pkg::OFS_IRQ_MASK, 32'h1 << i);
         ack();
         setf(6'h1 << i);
         cyc(4);
         setf(6'h0);
         cyc(4);
         chk("irq held", 32'h1, 32'(irq_flag));
         chk("irq pin", 32'h1, 32'(pin_o[0]));
         apb(1'b0, spi_pkg::OFS_IRQ_STATUS, 32'h0);
         chk("irq status", 32'h1 << i, rd);
         ack();
         chk("irq acked", 32'h0, 32'(irq_flag));
         apb(1'b0, spi_pkg::OFS_IRQ_STATUS, 32'h0);
         chk("irq status cleared", 32'h0, rd);
         setf(6'h1 << i);
         cyc(4);
         chk("irq rearmed", 32'h1, 32'(irq_flag));
         ack();
         setf(6'h0);
         cyc(4);
         chk("irq on fall", 32'(i != 4), 32'(irq_flag));
         ack();
         apb(1'b1, spi_pkg::OFS_IRQ_MASK, 32'h0);
         setf(6'h1 << i);
         cyc(4);
         chk("irq masked", 32'h0, 32'(irq_flag));
      end
      apb(1'b1, spi_pkg::OFS_CTRL, 32'h2);
      cyc(1);
      chk("loop closed", 32'h1, 32'(loop_closed));
      apb(1'b1, spi_pkg::OFS_START_TW, 32'h0000_1234);
      apb(1'b0, spi_pkg::OFS_START_TW, 32'h0);
      chk("tuning word write", 32'h0000_1234, rd);
      for (int s = 0; s < 16; s++) begin
         rst(4'(s), 3);
         chk("tuning word", 32'(exp_tw(3'(s))), 32'(startup_tuning_word_reg));
         chk("clock source", 32'(s[3]), 32'(sample_clock_direct));
         chk("pins driven", 32'hf, 32'(pin_oe));
         chk("loop open", 32'h0, 32'(loop_closed));
         apb(1'b0, spi_pkg::OFS_STRAP, 32'h0);
         chk("strap reg", {18'h0, s[3] ? 6'h1 : 6'h28, 4'h1, 4'(s)}, rd);
      end
      test_done();
   end
endmodule : spi_status_irq_bench
